/* File: design/flag_control_decoder.sv */
// Notes on behaviour
// - Opcode fa clears the interrupt-enable flag; the instruction takes 8 clocks.
// - Opcodes 0f then 06 clear the task-switched flag in 5 clocks.
// - Opcode f5 inverts the carry flag in 2 clocks.
// - Opcode 9f copies the low flags byte into the accumulator high byte, 2 clocks.
// - Opcode 9e writes the accumulator high byte into the writable bits of the low flags byte, 3 clocks.
// - Opcode f9 sets the carry flag in 2 clocks.
// - Opcode fd sets the direction flag in 2 clocks.
// - The set-interrupt-enable instruction sets that flag, taking 8 clocks.
// - The clear-direction instruction clears the direction flag in 2 clocks.
// - The clear-carry instruction clears the carry flag in 2 clocks.
`timescale 1ns/10ps
module flag_control_decoder (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ibyte_valid,
  input wire logic [7:0] ibyte,
  output logic ibyte_ready,
  output logic instr_done,
  output logic instr_unknown,
  output logic carry_flag,
  output logic direction_flag,
  output logic irq_enable_flag,
  output logic task_switched_flag,
  output logic [7:0] accumulator_high_byte
);
  import flag_ctl_pkg::*;

  decode_if dec ();

  logic [7:0] flags_low_q;
  logic irq_en_q;
  logic dir_q;
  logic ts_q;
  logic [7:0] acc_high_q;
  logic decode_en_q;
  logic busy_q;
  logic prefix_q;
  logic [3:0] count_q;
  flag_op_e pend_op_q;
  logic [7:0] unknown_cnt_q;
  logic [7:0] done_cnt_q;
  logic ready_q;
  logic done_q;
  logic unknown_q;
  logic [31:0] rdata_q;
  logic readyout_q;
  logic dph_wr_q;
  logic [3:0] dph_addr_q;
  logic take;
  logic start;
  logic unknown_take;
  logic finish;
  logic addr_valid;
  logic sw_wr_ctrl;
  logic sw_wr_flags;
  logic sw_wr_acc;
  logic [31:0] flags_word;
  logic [31:0] status_word;
  logic [31:0] rdata_d;
  logic hresp_q;
  logic [7:0] acc_masked;
  logic [7:0] wr_masked;

  flag_op_decode u_decode (
    .dec(dec.decode)
  );

  // Decoder inputs
  assign dec.opcode_byte = ibyte;
  assign dec.prefix_seen = prefix_q;

  // Byte handshake and last cycle of a running instruction
  assign take = clk_en && ibyte_valid && ready_q;
  assign finish = clk_en && busy_q && (count_q == 4'h1);
  assign start = take && (dec.op != OP_PREFIX) && (dec.op != OP_NONE);
  assign unknown_take = take && (dec.op == OP_NONE);

  // AHB address phase qualifier
  assign addr_valid = clk_en && hsel && htrans[1] && hready;

  // Software writes land in the data phase; flag and accumulator writes are dropped while an instruction runs
  assign sw_wr_ctrl = clk_en && dph_wr_q && (dph_addr_q == ADDR_CTRL);
  assign sw_wr_flags = clk_en && dph_wr_q && (dph_addr_q == ADDR_FLAGS) && !busy_q;
  assign sw_wr_acc = clk_en && dph_wr_q && (dph_addr_q == ADDR_ACC) && !busy_q;

  // Read view of the flags
  always_comb begin
    flags_word = 32'h0000_0000;
    flags_word[7:0] = flags_low_q;
    flags_word[IRQ_EN_BIT] = irq_en_q;
    flags_word[DIR_BIT] = dir_q;
    flags_word[TS_BIT] = ts_q;
  end

  // Read view of the sequencer state and the event counters
  assign status_word = {8'h00, done_cnt_q, unknown_cnt_q, 6'h00, prefix_q, busy_q};

  // Per-bit masks for the low flags byte: writable bits pass, fixed bits keep their reset value
  for (genvar b = 0; b < 8; b++) begin : g_low_mask
    assign acc_masked[b] = LOW_FLAGS_WMASK[b] ? acc_high_q[b] : FLAGS_LOW_RESET[b];
    assign wr_masked[b] = LOW_FLAGS_WMASK[b] ? hwdata[b] : FLAGS_LOW_RESET[b];
  end

  // Read data chosen by the address-phase offset; unmapped offsets read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (haddr[3:0])
      ADDR_CTRL: rdata_d = {31'h0000_0000, decode_en_q};
      ADDR_FLAGS: rdata_d = flags_word;
      ADDR_ACC: rdata_d = {24'h00_0000, acc_high_q};
      ADDR_STATUS: rdata_d = status_word;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Instruction sequencer: load clock count minus one on start, count down, retire when the count reaches one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_q <= 1'b0;
      count_q <= 4'h0;
      pend_op_q <= OP_NONE;
    end else if (clk_en) begin
      if (finish) begin
        busy_q <= 1'b0;
      end else if (busy_q) begin
        count_q <= count_q - 4'h1;
      end else if (start) begin
        busy_q <= 1'b1;
        pend_op_q <= dec.op;
        count_q <= dec.clocks - 4'h1;
      end
    end
  end

  // Two-byte prefix: armed by its byte, dropped by whatever byte follows
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prefix_q <= 1'b0;
    end else if (take) begin
      prefix_q <= (dec.op == OP_PREFIX);
    end
  end

  // Byte ready: low from a start until the retiring clock, otherwise follows decode enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_q <= 1'b0;
    end else if (clk_en) begin
      if (start) begin
        ready_q <= 1'b0;
      end else if (!busy_q || finish) begin
        ready_q <= decode_en_q;
      end
    end
  end

  // One-cycle pulses for a retired instruction and for an unrecognised byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q <= 1'b0;
      unknown_q <= 1'b0;
    end else if (clk_en) begin
      done_q <= finish;
      unknown_q <= unknown_take;
    end
  end

  // Low flags byte and carry
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_low_q <= FLAGS_LOW_RESET;
    end else if (finish) begin
      unique case (pend_op_q)
        OP_INVERT_CARRY: flags_low_q[CARRY_BIT] <= !flags_low_q[CARRY_BIT];
        OP_SET_CARRY: flags_low_q[CARRY_BIT] <= 1'b1;
        OP_CLEAR_CARRY: flags_low_q[CARRY_BIT] <= 1'b0;
        OP_ACC_TO_FLAGS: flags_low_q <= acc_masked;
        default: flags_low_q <= flags_low_q;
      endcase
    end else if (sw_wr_flags) begin
      flags_low_q <= wr_masked;
    end
  end

  // Interrupt-enable flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_en_q <= 1'b0;
    end else if (finish && pend_op_q == OP_CLEAR_IRQ) begin
      irq_en_q <= 1'b0;
    end else if (finish && pend_op_q == OP_SET_IRQ) begin
      irq_en_q <= 1'b1;
    end else if (sw_wr_flags) begin
      irq_en_q <= hwdata[IRQ_EN_BIT];
    end
  end

  // Direction flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir_q <= 1'b0;
    end else if (finish && pend_op_q == OP_SET_DIR) begin
      dir_q <= 1'b1;
    end else if (finish && pend_op_q == OP_CLEAR_DIR) begin
      dir_q <= 1'b0;
    end else if (sw_wr_flags) begin
      dir_q <= hwdata[DIR_BIT];
    end
  end

  // Task-switched flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ts_q <= 1'b0;
    end else if (finish && pend_op_q == OP_CLEAR_TS) begin
      ts_q <= 1'b0;
    end else if (sw_wr_flags) begin
      ts_q <= hwdata[TS_BIT];
    end
  end

  // Accumulator high byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_high_q <= ACC_HIGH_RESET;
    end else if (finish && pend_op_q == OP_FLAGS_TO_ACC) begin
      acc_high_q <= flags_low_q;
    end else if (sw_wr_acc) begin
      acc_high_q <= hwdata[7:0];
    end
  end

  // Decode enable, written through the control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      decode_en_q <= 1'b0;
    end else if (sw_wr_ctrl) begin
      decode_en_q <= hwdata[0];
    end
  end

  // Event counters for unknown bytes and retired instructions; both wrap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unknown_cnt_q <= 8'h00;
      done_cnt_q <= 8'h00;
    end else if (clk_en) begin
      if (unknown_take) begin
        unknown_cnt_q <= unknown_cnt_q + 8'h01;
      end
      if (finish) begin
        done_cnt_q <= done_cnt_q + 8'h01;
      end
    end
  end

  // AHB-Lite slave: capture address phase, answer with zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_q <= 1'b0;
      dph_addr_q <= 4'h0;
      rdata_q <= 32'h0000_0000;
      readyout_q <= 1'b1;
    end else if (clk_en) begin
      readyout_q <= 1'b1;
      dph_wr_q <= addr_valid && hwrite;
      dph_addr_q <= haddr[3:0];
      if (addr_valid && !hwrite) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // Response code: every transfer completes OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_q <= 1'b0;
    end else if (clk_en) begin
      hresp_q <= 1'b0;
    end
  end

  // Output drive
  assign hrdata = rdata_q;
  assign hreadyout = readyout_q;
  assign hresp = hresp_q;
  assign ibyte_ready = ready_q;
  assign instr_done = done_q;
  assign instr_unknown = unknown_q;
  assign carry_flag = flags_low_q[CARRY_BIT];
  assign direction_flag = dir_q;
  assign irq_enable_flag = irq_en_q;
  assign task_switched_flag = ts_q;
  assign accumulator_high_byte = acc_high_q;

endmodule : flag_control_decoder

/* File: design/flag_ctl_pkg.sv */
package flag_ctl_pkg;

  // Opcode bytes
  localparam logic [7:0] OPC_CLEAR_IRQ = 8'hfa;
  localparam logic [7:0] OPC_SET_IRQ = 8'hfb;
  localparam logic [7:0] OPC_TWO_BYTE = 8'h0f;
  localparam logic [7:0] OPC_CLEAR_TS_2ND = 8'h06;
  localparam logic [7:0] OPC_INVERT_CARRY = 8'hf5;
  localparam logic [7:0] OPC_FLAGS_TO_ACC = 8'h9f;
  localparam logic [7:0] OPC_ACC_TO_FLAGS = 8'h9e;
  localparam logic [7:0] OPC_SET_CARRY = 8'hf9;
  localparam logic [7:0] OPC_CLEAR_CARRY = 8'hf8;
  localparam logic [7:0] OPC_SET_DIR = 8'hfd;
  localparam logic [7:0] OPC_CLEAR_DIR = 8'hfc;

  // Clock counts per instruction
  localparam logic [3:0] CLK_IRQ = 4'h8;
  localparam logic [3:0] CLK_CLEAR_TS = 4'h5;
  localparam logic [3:0] CLK_SIMPLE = 4'h2;
  localparam logic [3:0] CLK_ACC_TO_FLAGS = 4'h3;

  // Register byte addresses
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_FLAGS = 4'h4;
  localparam logic [3:0] ADDR_ACC = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hc;

  // Field positions in the flags register
  localparam int CARRY_BIT = 0;
  localparam int FIXED_ONE_BIT = 1;
  localparam int IRQ_EN_BIT = 9;
  localparam int DIR_BIT = 10;
  localparam int TS_BIT = 16;

  // Values after reset, and the write mask of the low flags byte
  localparam logic [7:0] FLAGS_LOW_RESET = 8'h02;
  localparam logic [7:0] ACC_HIGH_RESET = 8'h00;
  localparam logic [7:0] LOW_FLAGS_WMASK = 8'hd5;

  typedef enum {
    OP_NONE,
    OP_PREFIX,
    OP_CLEAR_IRQ,
    OP_SET_IRQ,
    OP_CLEAR_TS,
    OP_INVERT_CARRY,
    OP_FLAGS_TO_ACC,
    OP_ACC_TO_FLAGS,
    OP_SET_CARRY,
    OP_CLEAR_CARRY,
    OP_SET_DIR,
    OP_CLEAR_DIR
  } flag_op_e;

endpackage : flag_ctl_pkg

/* File: design/decode_if.sv */
`timescale 1ns/10ps
interface decode_if;
  import flag_ctl_pkg::*;
  logic [7:0] opcode_byte;
  logic prefix_seen;
  flag_op_e op;
  logic [3:0] clocks;

  modport exec (output opcode_byte, output prefix_seen, input op, input clocks);
  modport decode (input opcode_byte, input prefix_seen, output op, output clocks);
endinterface : decode_if

/* File: design/flag_op_decode.sv */
`timescale 1ns/10ps
module flag_op_decode (
  decode_if.decode dec
);
  import flag_ctl_pkg::*;

  // Maps an opcode byte, after or without the two-byte prefix, to an operation and its clock count
  always_comb begin
    dec.op = OP_NONE;
    dec.clocks = CLK_SIMPLE;
    if (dec.prefix_seen) begin
      if (dec.opcode_byte == OPC_CLEAR_TS_2ND) begin
        dec.op = OP_CLEAR_TS;
        dec.clocks = CLK_CLEAR_TS;
      end
    end else begin
      unique case (dec.opcode_byte)
        OPC_TWO_BYTE: dec.op = OP_PREFIX;
        OPC_CLEAR_IRQ: begin
          dec.op = OP_CLEAR_IRQ;
          dec.clocks = CLK_IRQ;
        end
        OPC_SET_IRQ: begin
          dec.op = OP_SET_IRQ;
          dec.clocks = CLK_IRQ;
        end
        OPC_INVERT_CARRY: dec.op = OP_INVERT_CARRY;
        OPC_FLAGS_TO_ACC: dec.op = OP_FLAGS_TO_ACC;
        OPC_ACC_TO_FLAGS: begin
          dec.op = OP_ACC_TO_FLAGS;
          dec.clocks = CLK_ACC_TO_FLAGS;
        end
        OPC_SET_CARRY: dec.op = OP_SET_CARRY;
        OPC_SET_DIR: dec.op = OP_SET_DIR;
        OPC_CLEAR_DIR: dec.op = OP_CLEAR_DIR;
        OPC_CLEAR_CARRY: dec.op = OP_CLEAR_CARRY;
        default: dec.op = OP_NONE;
      endcase
    end
  end

endmodule : flag_op_decode

/* File: testbench/flag_control_decoder_assertions.sv */
`timescale 1ns/10ps
module flag_control_decoder_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic ibyte_valid,
  input wire logic [7:0] ibyte,
  input wire logic ibyte_ready,
  input wire logic instr_done,
  input wire logic carry_flag,
  input wire logic direction_flag,
  input wire logic irq_enable_flag,
  input wire logic task_switched_flag,
  input wire logic [7:0] accumulator_high_byte
);
  import flag_ctl_pkg::*;
  logic take;
  // Opcode byte accepted at this edge
  assign take = ibyte_valid && ibyte_ready && clk_en;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence take_of(logic [7:0] b);
    take && ibyte == b;
  endsequence
  // Prefix byte followed at once by its second byte
  sequence ts_pair;
    take_of(OPC_TWO_BYTE) ##1 take_of(OPC_CLEAR_TS_2ND);
  endsequence
  property inv_carry;
    logic v;
    (take_of(OPC_INVERT_CARRY), v = carry_flag) |-> ##2 instr_done && carry_flag != v;
  endproperty
  property acc_to_flags;
    logic [7:0] a;
    (take_of(OPC_ACC_TO_FLAGS), a = accumulator_high_byte) |-> ##3 instr_done && carry_flag == a[0];
  endproperty
  AST_CLR_IRQ: assert property (take_of(OPC_CLEAR_IRQ) |-> ##1 !instr_done [*7] ##1 instr_done && !irq_enable_flag)
    else $error("clear irq enable wrong");
  AST_CLR_TS: assert property (ts_pair |-> ##5 instr_done && !task_switched_flag)
    else $error("clear task switched wrong");
  AST_INV_CARRY: assert property (inv_carry)
    else $error("invert carry wrong");
  AST_FLAGS_TO_ACC: assert property (take_of(OPC_FLAGS_TO_ACC) |-> ##2 instr_done && accumulator_high_byte[1:0] == {1'b1, carry_flag})
    else $error("flags to acc wrong");
  AST_ACC_TO_FLAGS: assert property (acc_to_flags)
    else $error("acc to flags wrong");
  AST_SET_CARRY: assert property (take_of(OPC_SET_CARRY) |-> ##2 instr_done && carry_flag)
    else $error("set carry wrong");
  AST_SET_DIR: assert property (take_of(OPC_SET_DIR) |-> ##1 !instr_done ##1 instr_done && direction_flag)
    else $error("set direction wrong");
  AST_SET_IRQ: assert property (take_of(OPC_SET_IRQ) |-> ##1 !instr_done [*7] ##1 instr_done && irq_enable_flag)
    else $error("set irq enable wrong");
  AST_CLR_DIR: assert property (take_of(OPC_CLEAR_DIR) |-> ##2 instr_done && !direction_flag)
    else $error("clear direction wrong");
  AST_CLR_CARRY: assert property (take_of(OPC_CLEAR_CARRY) |-> ##2 instr_done && !carry_flag)
    else $error("clear carry wrong");
endmodule : flag_control_decoder_assertions

/* File: testbench/flag_control_decoder_bench.sv */
`timescale 1ns/10ps
module flag_control_decoder_bench;
  import flag_ctl_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic clk_en = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic ibyte_valid = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] ibyte = 8'h00;
  logic [31:0] hrdata, r, w;
  logic [7:0] accumulator_high_byte;
  logic hreadyout, hresp, ibyte_ready, instr_done, instr_unknown;
  logic carry_flag, direction_flag, irq_enable_flag, task_switched_flag;
  logic [7:0] lo = FLAGS_LOW_RESET;
  logic [7:0] acc = 8'h00;
  logic d = 1'b0;
  logic i = 1'b0;
  logic t = 1'b0;
  int seed = 32'hd163;
  int failures = 0;
  int check_count = 0;

  flag_control_decoder dut (.*, .hsize(3'h2), .hready(hreadyout));

  // Free running clock
  always #5 hclk = ~hclk;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task end_sim;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  // Expected FLAGS register word from the model
  function logic [31:0] flags_word();
    return {15'h0, t, 5'h0, d, i, 1'b0, lo};
  endfunction : flags_word

  // One single-word AHB transfer; read data lands in r
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] dat);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= dat;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb

  // Offer a byte and return at the edge that takes it
  task instr(input logic [7:0] b);
    ibyte <= b;
    ibyte_valid <= 1'b1;
    do @(posedge hclk); while (ibyte_ready !== 1'b1);
  endtask : instr

  // Run one instruction, then check clock count and state
  task op(input logic [7:0] b, input int n);
    int c;
    c = 0;
    if (b == OPC_CLEAR_TS_2ND) instr(OPC_TWO_BYTE);
    instr(b);
    ibyte_valid <= 1'b0;
    case (b)
      OPC_CLEAR_IRQ: i = 1'b0;
      OPC_SET_IRQ: i = 1'b1;
      OPC_CLEAR_TS_2ND: t = 1'b0;
      OPC_INVERT_CARRY: lo[0] = !lo[0];
      OPC_FLAGS_TO_ACC: acc = lo;
      OPC_ACC_TO_FLAGS: lo = (acc & LOW_FLAGS_WMASK) | FLAGS_LOW_RESET;
      OPC_SET_CARRY: lo[0] = 1'b1;
      OPC_CLEAR_CARRY: lo[0] = 1'b0;
      OPC_SET_DIR: d = 1'b1;
      default: d = 1'b0;
    endcase
    do begin
      @(posedge hclk);
      c++;
    end while (instr_done !== 1'b1 && c < 20);
    check(32'(c), 32'(n));
    check({carry_flag, direction_flag, irq_enable_flag, task_switched_flag, accumulator_high_byte}, {lo[0], d, i, t, acc});
  endtask : op

  // Main sequence
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b1, 32'(ADDR_CTRL), 32'h1);
    clk_en <= 1'b0;
    repeat (3) @(posedge hclk);
    clk_en <= 1'b1;
    instr(OPC_TWO_BYTE);
    instr(8'h37);
    ibyte_valid <= 1'b0;
    @(posedge hclk);
    check(instr_unknown, 1'b1);
    repeat (8) begin
      w = $random(seed);
      ahb(1'b1, 32'(ADDR_FLAGS), w);
      lo = (w[7:0] & LOW_FLAGS_WMASK) | FLAGS_LOW_RESET;
      i = w[9];
      d = w[10];
      t = w[16];
      w = $random(seed);
      ahb(1'b1, 32'(ADDR_ACC), w);
      acc = w[7:0];
      op(OPC_ACC_TO_FLAGS, 3);
      op(OPC_CLEAR_TS_2ND, 5);
      op(OPC_INVERT_CARRY, 2);
      op(OPC_FLAGS_TO_ACC, 2);
      op(OPC_CLEAR_IRQ, 8);
      op(OPC_SET_IRQ, 8);
      op(OPC_SET_CARRY, 2);
      op(OPC_SET_DIR, 2);
      op(OPC_CLEAR_DIR, 2);
      op(OPC_CLEAR_CARRY, 2);
      ahb(1'b0, 32'(ADDR_FLAGS), 32'h0);
      check(r, flags_word());
      ahb(1'b0, 32'(ADDR_ACC), 32'h0);
      check(r, {24'h0, acc});
    end
    ahb(1'b0, 32'(ADDR_STATUS), 32'h0);
    check(r, {8'h00, 8'h50, 8'h01, 8'h00});
    end_sim();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    end_sim();
  end
endmodule : flag_control_decoder_bench

bind flag_control_decoder flag_control_decoder_assertions chk (.*);
